/* File: rtl/deformat_pkg.sv */
package deformat_pkg;
    // Function
    // - chroma ancillary flag stays high across every whole chroma ancillary packet
    // - ancillary flag length follows the packet's data count word
    // - only an exact ancillary header match raises a presence flag
    // - four-bit format code, including unknown interlaced and unknown progressive codes
    // - chroma line CRC compared with embedded CRC; flag high on mismatch
    // - luma line CRC compared with embedded CRC; flag high on mismatch
    // - fifo load strobe normally high, low for one EAV or SAV word
    // - output buses driven while output enable low, floated while high
    // - chroma word on bus bits 9..0, bit 9 most significant
    // - luma word on bus bits 19..10, bit 19 most significant
    // - line fault on bad line number or flywheel line mismatch when enabled
    // - line numbers judged by sequence, so one bad number flags two lines
    // - luma ancillary flag stays high across every whole luma ancillary packet

    localparam int WORD_W = 10;
    localparam int PIPE_DEPTH = 6;
    localparam int CRC_W = 18;
    localparam int LINE_W = 11;
    localparam int COUNT_W = 12;
    localparam int CNT_W = 9;
    localparam int STATUS_W = 6;
    localparam int CTRL_W = 2;
    localparam int FMT_W = 4;

    localparam logic [WORD_W-1:0] TRS_ONES = 10'h3ff;
    localparam logic [WORD_W-1:0] TRS_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] ANC_TAIL_WORDS = 9'h006;
    localparam int XYZ_H_BIT = 6;
    localparam int XYZ_F_BIT = 7;

    localparam logic [2:0] POS_IDLE = 3'h0;
    localparam logic [2:0] POS_LN0 = 3'h1;
    localparam logic [2:0] POS_LN1 = 3'h2;
    localparam logic [2:0] POS_CR0 = 3'h3;
    localparam logic [2:0] POS_CR1 = 3'h4;
    localparam logic [LINE_W-1:0] FIRST_LINE = 11'h001;

    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_MASK = 5'h04;
    localparam logic [4:0] REG_CONTROL = 5'h08;
    localparam logic [4:0] REG_FORMAT = 5'h0c;
    localparam logic [4:0] REG_LINE = 5'h10;

    localparam int CTRL_FLY_BIT = 0;
    localparam int CTRL_SAV_BIT = 1;
    localparam logic [STATUS_W-1:0] MASK_RESET = 6'h00;
    localparam logic [CTRL_W-1:0] CONTROL_RESET = 2'h0;
    localparam logic [FMT_W-1:0] FMT_UNKNOWN_I = 4'he;
    localparam logic [FMT_W-1:0] FMT_UNKNOWN_P = 4'hf;

    localparam int NUM_FORMATS = 4;
    localparam logic [LINE_W-1:0] FMT_LINES [NUM_FORMATS] = '{11'h465, 11'h465, 11'h2ee, 11'h2ee};
    localparam logic [COUNT_W-1:0] FMT_WORDS [NUM_FORMATS] = '{12'h898, 12'ha50, 12'h672, 12'h7bc};
    localparam logic FMT_INTERLACED [NUM_FORMATS] = '{1'b1, 1'b1, 1'b0, 1'b0};
    localparam logic [FMT_W-1:0] FMT_CODES [NUM_FORMATS] = '{4'h0, 4'h1, 4'h2, 4'h3};

    typedef struct packed {
        logic [WORD_W-1:0] luma;
        logic [WORD_W-1:0] chroma;
    } video_word_t;

    typedef struct packed {
        logic luma_anc;
        logic chroma_anc;
        logic format_change;
        logic line_fault;
        logic luma_crc;
        logic chroma_crc;
    } status_t;
endpackage

/* File: rtl/video_deformat_output_status.sv */
`timescale 1ns/1ps
module video_deformat_output_status
    import deformat_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire video_word_t video_in,
    input wire logic output_enable_n,
    output video_word_t video_out,
    output logic video_out_oe_n,
    output logic chroma_anc_present,
    output logic luma_anc_present,
    output logic [FMT_W-1:0] detected_format_code,
    output logic chroma_crc_error,
    output logic luma_crc_error,
    output logic line_number_fault,
    output logic fifo_load_n,
    output logic irq,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest
);

    function automatic logic parity_ok(input logic [WORD_W-1:0] w);
        return (w[8] == ^w[7:0]) && (w[9] == ~w[8]);
    endfunction

    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                  input logic [WORD_W-1:0] d);
        logic [CRC_W-1:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < WORD_W; i++) begin
            fb = r[0] ^ d[i];
            r = {fb, r[17:14], r[13] ^ fb, r[12] ^ fb, r[11:1]};
        end
        return r;
    endfunction

    logic [WORD_W-1:0] ch_in [2];
    logic [WORD_W-1:0] ch_head [2];
    logic [WORD_W-1:0] ch_out [2];
    logic ch_xyz [2];
    logic ch_anc [2];
    logic ch_anc_hit [2];
    logic ch_crc_err [2];
    logic ch_crc_evt [2];

    logic [2:0] pos_q;
    logic [2:0] pos_d;
    logic [CTRL_W-1:0] control_q;
    logic [STATUS_W-1:0] mask_q;
    logic [STATUS_W-1:0] status_q;
    logic fifo_load_n_q;

    wire fly_en = control_q[CTRL_FLY_BIT];
    wire sav_sel = control_q[CTRL_SAV_BIT];
    wire luma_xyz = ch_xyz[1];
    wire luma_eav = ch_xyz[1] & ch_head[1][XYZ_H_BIT];
    wire luma_sav = ch_xyz[1] & ~ch_head[1][XYZ_H_BIT];

    assign ch_in[0] = video_in.chroma;
    assign ch_in[1] = video_in.luma;

    // post-EAV word position, shared by both channels
    assign pos_d = luma_eav ? POS_LN0 :
                   (pos_q == POS_IDLE || pos_q == POS_CR1) ? POS_IDLE : pos_q + 3'h1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pos_q <= POS_IDLE;
        end else if (clk_en) begin
            pos_q <= pos_d;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [WORD_W-1:0] pipe_q [PIPE_DEPTH];
        logic [WORD_W-1:0] out_q;
        logic [WORD_W-1:0] h1_q;
        logic [WORD_W-1:0] h2_q;
        logic [CNT_W-1:0] anc_cnt_q;
        logic anc_q;
        logic [CRC_W-1:0] crc_q;
        logic in_crc_q;
        logic lo_bad_q;
        logic err_q;

        // header must already sit fully in the pipe so the flag can start on ADF
        wire anc_busy = anc_cnt_q != '0;
        wire hdr_hit = ~anc_busy
            && pipe_q[PIPE_DEPTH-1] == TRS_ZERO
            && pipe_q[PIPE_DEPTH-2] == TRS_ONES
            && pipe_q[PIPE_DEPTH-3] == TRS_ONES
            && parity_ok(pipe_q[2]) && parity_ok(pipe_q[1])
            && parity_ok(pipe_q[0]);
        wire [CNT_W-1:0] anc_len = {1'b0, pipe_q[0][7:0]} + ANC_TAIL_WORDS;
        wire [WORD_W-1:0] head = pipe_q[PIPE_DEPTH-1];
        wire xyz = h2_q == TRS_ONES && h1_q == TRS_ZERO && out_q == TRS_ZERO;
        wire hi_bad = head[8:0] != crc_q[17:9];

        assign ch_head[ch] = head;
        assign ch_xyz[ch] = xyz;
        assign ch_out[ch] = out_q;
        assign ch_anc[ch] = anc_q;
        assign ch_anc_hit[ch] = hdr_hit & clk_en;
        assign ch_crc_err[ch] = err_q;
        assign ch_crc_evt[ch] = clk_en && pos_q == POS_CR1 && (lo_bad_q | hi_bad);

        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                for (int i = 0; i < PIPE_DEPTH; i++) begin
                    pipe_q[i] <= TRS_ZERO;
                end
                out_q <= TRS_ZERO;
                h1_q <= TRS_ZERO;
                h2_q <= TRS_ZERO;
            end else if (clk_en) begin
                pipe_q[0] <= ch_in[ch];
                for (int i = 1; i < PIPE_DEPTH; i++) begin
                    pipe_q[i] <= pipe_q[i-1];
                end
                out_q <= head;
                h1_q <= out_q;
                h2_q <= h1_q;
            end
        end

        // flag covers ADF, DID, SDID, DC, data and checksum
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                anc_cnt_q <= '0;
                anc_q <= 1'b0;
            end else if (clk_en) begin
                if (hdr_hit) begin
                    anc_cnt_q <= anc_len;
                end else if (anc_busy) begin
                    anc_cnt_q <= anc_cnt_q - 9'h001;
                end
                anc_q <= hdr_hit | anc_busy;
            end
        end

        // CRC spans first active word through LN1 of the following EAV
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                crc_q <= '0;
                in_crc_q <= 1'b0;
                lo_bad_q <= 1'b0;
                err_q <= 1'b0;
            end else if (clk_en) begin
                if (luma_sav) begin
                    crc_q <= '0;
                    in_crc_q <= 1'b1;
                end else if (in_crc_q) begin
                    crc_q <= crc_step(crc_q, head);
                    if (pos_q == POS_LN1) begin
                        in_crc_q <= 1'b0;
                    end
                end
                if (pos_q == POS_CR0) begin
                    lo_bad_q <= head[8:0] != crc_q[8:0];
                end
                if (pos_q == POS_CR1) begin
                    err_q <= lo_bad_q | hi_bad;
                end
            end
        end
    end

    assign video_out.chroma = ch_out[0];
    assign video_out.luma = ch_out[1];
    assign video_out_oe_n = output_enable_n;
    assign chroma_anc_present = ch_anc[0];
    assign luma_anc_present = ch_anc[1];
    assign chroma_crc_error = ch_crc_err[0];
    assign luma_crc_error = ch_crc_err[1];
    assign fifo_load_n = fifo_load_n_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fifo_load_n_q <= 1'b1;
        end else if (clk_en) begin
            fifo_load_n_q <= ~(luma_xyz & (ch_head[1][XYZ_H_BIT] != sav_sel));
        end
    end

    // line number check, taken from the luma channel
    logic [WORD_W-1:0] ln_lo_q;
    logic [LINE_W-1:0] prev_ln_q;
    logic prev_valid_q;
    logic [LINE_W-1:0] fly_ln_q;
    logic fault_q;

    wire [LINE_W-1:0] ln_now = {ch_head[1][5:2], ln_lo_q[8:2]};
    wire ln_word_ok = ln_lo_q[9] == ~ln_lo_q[8] && ch_head[1][9] == ~ch_head[1][8];
    wire ln_wrap = ln_now == FIRST_LINE;
    wire seq_bad = prev_valid_q && !ln_wrap && ln_now != prev_ln_q + 11'h001;
    wire fly_bad = fly_en && prev_valid_q && ln_now != fly_ln_q;
    wire ln_take = clk_en && pos_q == POS_LN1;
    wire ln_bad = ~ln_word_ok | seq_bad | fly_bad;

    assign line_number_fault = fault_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ln_lo_q <= TRS_ZERO;
            prev_ln_q <= '0;
            prev_valid_q <= 1'b0;
            fly_ln_q <= FIRST_LINE;
            fault_q <= 1'b0;
        end else if (clk_en) begin
            if (pos_q == POS_LN0) begin
                ln_lo_q <= ch_head[1];
            end
            if (pos_q == POS_LN1) begin
                fault_q <= ln_bad;
                prev_ln_q <= ln_now;
                prev_valid_q <= 1'b1;
                fly_ln_q <= (fly_en && !ln_wrap) ? fly_ln_q + 11'h001 : ln_now + 11'h001;
            end
        end
    end

    // format measurement: words per line, lines per frame, interlace
    logic [COUNT_W-1:0] word_cnt_q;
    logic [COUNT_W-1:0] words_q;
    logic f_seen_q;
    logic [FMT_W-1:0] fmt_q;
    logic [NUM_FORMATS-1:0] fmt_match;
    logic [FMT_W-1:0] fmt_d;

    wire frame_end = ln_take && ln_wrap && prev_valid_q;
    wire fmt_evt = frame_end && fmt_d != fmt_q;

    for (genvar f = 0; f < NUM_FORMATS; f++) begin : g_fmt
        assign fmt_match[f] = prev_ln_q == FMT_LINES[f] && words_q == FMT_WORDS[f]
                              && f_seen_q == FMT_INTERLACED[f];
    end

    always_comb begin
        fmt_d = f_seen_q ? FMT_UNKNOWN_I : FMT_UNKNOWN_P;
        for (int f = NUM_FORMATS - 1; f >= 0; f--) begin
            if (fmt_match[f]) begin
                fmt_d = FMT_CODES[f];
            end
        end
    end

    assign detected_format_code = fmt_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            word_cnt_q <= '0;
            words_q <= '0;
            f_seen_q <= 1'b0;
            fmt_q <= FMT_UNKNOWN_P;
        end else if (clk_en) begin
            if (luma_eav) begin
                words_q <= word_cnt_q;
                word_cnt_q <= 12'h001;
            end else if (word_cnt_q != '1) begin
                word_cnt_q <= word_cnt_q + 12'h001;
            end
            if (frame_end) begin
                fmt_q <= fmt_d;
                f_seen_q <= 1'b0;
            end else if (luma_xyz && ch_head[1][XYZ_F_BIT]) begin
                f_seen_q <= 1'b1;
            end
        end
    end

    // register slave; reads take one wait cycle so read data comes from a flop
    logic rd_done_q;
    logic [31:0] rd_data_q;
    status_t events;
    logic [31:0] rd_mux;

    wire rd_accept = read & rd_done_q & clk_en;
    wire wr_accept = write & clk_en;
    wire sel_status = address == REG_STATUS;
    wire sel_mask = address == REG_MASK;
    wire sel_control = address == REG_CONTROL;
    wire sel_format = address == REG_FORMAT;
    wire sel_line = address == REG_LINE;
    wire [STATUS_W-1:0] status_clr = (rd_accept && sel_status) ? rd_data_q[STATUS_W-1:0] : '0;

    assign events.chroma_crc = ch_crc_evt[0];
    assign events.luma_crc = ch_crc_evt[1];
    assign events.line_fault = ln_take & ln_bad;
    assign events.format_change = fmt_evt;
    assign events.chroma_anc = ch_anc_hit[0];
    assign events.luma_anc = ch_anc_hit[1];

    assign rd_mux = sel_status ? {26'h0, status_q} :
                    sel_mask ? {26'h0, mask_q} :
                    sel_control ? {30'h0, control_q} :
                    sel_format ? {28'h0, fmt_q} :
                    sel_line ? {21'h0, prev_ln_q} : 32'h0;

    assign waitrequest = (read & ~(rd_done_q & clk_en)) | (write & ~clk_en);
    assign readdata = rd_data_q;
    assign irq = |(status_q & mask_q);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_done_q <= 1'b0;
            rd_data_q <= 32'h0;
        end else if (clk_en) begin
            rd_done_q <= read & ~rd_done_q;
            if (read & ~rd_done_q) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // a new event wins over the clear of an already reported bit
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q <= '0;
            mask_q <= MASK_RESET;
            control_q <= CONTROL_RESET;
        end else if (clk_en) begin
            status_q <= (status_q & ~status_clr) | events;
            if (wr_accept && byteenable[0] && sel_mask) begin
                mask_q <= writedata[STATUS_W-1:0];
            end
            if (wr_accept && byteenable[0] && sel_control) begin
                control_q <= writedata[CTRL_W-1:0];
            end
        end
    end

endmodule // video_deformat_output_status

/* File: bench/deformat_chk.sv */
`timescale 1ns/1ps
module deformat_chk
    import deformat_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic output_enable_n,
    input wire logic read,
    input wire logic write,
    input wire video_word_t video_out,
    input wire logic video_out_oe_n,
    input wire logic chroma_anc_present,
    input wire logic luma_anc_present,
    input wire logic chroma_crc_error,
    input wire logic luma_crc_error,
    input wire logic line_number_fault,
    input wire logic fifo_load_n,
    input wire logic waitrequest
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // run length of the chroma flag and the count word seen at offset five
    logic [8:0] run_q;
    logic [8:0] dc_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= '0;
            dc_q <= '0;
        end else begin
            run_q <= chroma_anc_present ? run_q + 9'h001 : 9'h000;
            if (run_q == 9'h005) dc_q <= {1'b0, video_out.chroma[7:0]};
        end
    end
    AST_OE_PASS: assert property (video_out_oe_n == output_enable_n)
        else $error("bus enable not passed through");
    AST_ANC_C_HDR: assert property ($rose(chroma_anc_present) |-> video_out.chroma == TRS_ZERO
        ##1 (video_out.chroma == TRS_ONES) [*2]) else $error("chroma flag without header");
    AST_ANC_Y_HDR: assert property ($rose(luma_anc_present) |-> video_out.luma == TRS_ZERO
        ##1 (video_out.luma == TRS_ONES) [*2]) else $error("luma flag without header");
    AST_ANC_LEN: assert property ($fell(chroma_anc_present) |-> run_q == dc_q + 9'h007)
        else $error("chroma flag length wrong");
    AST_FIFO_ONE: assert property (!fifo_load_n |=> fifo_load_n)
        else $error("load strobe low too long");
    AST_FIFO_XYZ: assert property (!fifo_load_n |-> $past(video_out.luma, 3) == TRS_ONES
        && $past(video_out.luma, 1) == TRS_ZERO) else $error("load strobe off timing word");
    AST_CRC_C: assert property ($changed(chroma_crc_error) |-> $past(video_out.luma, 7) == TRS_ONES)
        else $error("chroma crc flag moved off check word");
    AST_CRC_Y: assert property ($changed(luma_crc_error) |-> $past(video_out.luma, 7) == TRS_ONES)
        else $error("luma crc flag moved off check word");
    AST_LINE: assert property ($changed(line_number_fault) |-> $past(video_out.luma, 5) == TRS_ONES)
        else $error("line fault moved off line word");
    AST_WR_NOWAIT: assert property (write && clk_en |-> !waitrequest)
        else $error("write stalled");
    AST_RD_WAIT: assert property (read && !$past(read) && clk_en |-> waitrequest ##1 !waitrequest)
        else $error("read answer timing wrong");
endmodule // deformat_chk
bind video_deformat_output_status deformat_chk deformat_chk_i (.*);

/* File: bench/video_sink.sv */
`timescale 1ns/1ps
module video_sink (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [19:0] bus,
    input wire logic fifo_load_n,
    input wire logic bus_off,
    output logic output_enable_n,
    output int loads,
    output logic [19:0] last_load
);
    // far side owns the enable; async pin, so no register
    assign output_enable_n = bus_off;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            loads <= 0;
            last_load <= '0;
        end else if (!fifo_load_n) begin
            loads <= loads + 1;
            last_load <= bus;
        end
    end
endmodule // video_sink

/* File: bench/video_deformat_output_status_tb.sv */
`timescale 1ns/1ps
module video_deformat_output_status_tb;
    import deformat_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch %0t got %h want %h", $time, a, b); end end
    typedef struct packed {
        video_word_t w;
        logic ac, ay, fl, care, ec, ey, lf;
    } exp_t;
    logic clock = 0, resetn = 0, bus_off = 0, read = 0, write = 0, clk_en = 1;
    video_word_t video_in = '0, video_out;
    logic [4:0] address = '0;
    logic [31:0] writedata = '0, readdata, rd;
    logic video_out_oe_n, chroma_anc_present, luma_anc_present, chroma_crc_error, luma_crc_error;
    logic line_number_fault, fifo_load_n, irq, waitrequest, output_enable_n;
    logic [3:0] detected_format_code;
    logic [19:0] last_load;
    wire [19:0] out_bus = video_out_oe_n ? 20'hzzzzz : video_out;
    int num_errors = 0, compares = 0, loads;
    exp_t q[$], e;
    logic [17:0] crc_c = '0, crc_y = '0;
    logic [10:0] prev_ln = '0, fly_ln = '0;
    logic sav_sel = 0, bad_c = 0, bad_y = 0, lf_exp = 0, fly = 0, fld = 0;
    logic [10:0] lns [11] = '{1, 2, 3, 4, 5, 40, 7, 8, 9, 10, 1};
    video_deformat_output_status video_deformat_output_status_i (.clock(clock), .resetn(resetn),
        .clk_en(clk_en), .video_in(video_in), .output_enable_n(output_enable_n),
        .video_out(video_out), .video_out_oe_n(video_out_oe_n),
        .chroma_anc_present(chroma_anc_present), .luma_anc_present(luma_anc_present),
        .detected_format_code(detected_format_code), .chroma_crc_error(chroma_crc_error),
        .luma_crc_error(luma_crc_error), .line_number_fault(line_number_fault),
        .fifo_load_n(fifo_load_n), .irq(irq), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest));
    video_sink video_sink_i (.clock(clock), .resetn(resetn), .bus(out_bus),
        .fifo_load_n(fifo_load_n), .bus_off(bus_off), .output_enable_n(output_enable_n),
        .loads(loads), .last_load(last_load));
    initial forever #25 clock = ~clock;
    function automatic logic [17:0] crc_step(logic [17:0] c, logic [9:0] d);
        logic fb;
        for (int i = 0; i < 10; i++) begin
            fb = c[0] ^ d[i];
            c = {fb, c[17:14], c[13] ^ fb, c[12] ^ fb, c[11:1]};
        end
        return c;
    endfunction
    function automatic logic [9:0] par(logic [7:0] v);
        return {~^v, ^v, v};
    endfunction
    task summarize;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        read <= 0;
        write <= 0;
    endtask
    // one word on both channels; expectation queued with it
    task put(input logic [9:0] y, input logic [9:0] c, input logic a, input logic f,
            input logic care);
        @(posedge clock);
        video_in <= {y, c};
        q.push_back(exp_t'({y, c, a, a, f, care, bad_c, bad_y, lf_exp}));
        crc_c = crc_step(crc_c, c);
        crc_y = crc_step(crc_y, y);
    endtask
    task gap(input int n);
        repeat (n) put(10'h004 + 10'($urandom_range(1000)), 10'h004 + 10'($urandom_range(1000)),
            0, 1, 0);
    endtask
    task send_line(input logic [10:0] ln, input logic [7:0] dc, input logic hdr, input logic care);
        logic [17:0] kc, ky;
        logic [9:0] h;
        // flywheel has no frame length, so a wrap counts as a mismatch
        lf_exp = (ln != 11'h001 && ln != prev_ln + 11'h001) || (fly && ln != fly_ln);
        prev_ln = ln;
        fly_ln = ln + 11'h001;
        h = hdr ? TRS_ONES : 10'h3fe;
        put(TRS_ONES, TRS_ONES, 0, 1, 0);
        repeat (2) put(TRS_ZERO, TRS_ZERO, 0, 1, 0);
        put(fld ? 10'h2f4 : 10'h274, fld ? 10'h2f4 : 10'h274, 0, sav_sel, 0);
        put({~ln[6], ln[6:0], 2'b00}, {~ln[6], ln[6:0], 2'b00}, 0, 1, 0);
        put({4'h8, ln[10:7], 2'b00}, {4'h8, ln[10:7], 2'b00}, 0, 1, 0);
        kc = crc_c;
        ky = crc_y;
        put({~ky[8], ky[8:0] ^ 9'(bad_y)}, {~kc[8], kc[8:0] ^ 9'(bad_c)}, 0, 1, 0);
        put({~ky[17], ky[17:9]}, {~kc[17], kc[17:9]}, 0, 1, 0);
        put(TRS_ZERO, TRS_ZERO, hdr, 1, 0);
        put(h, h, hdr, 1, 0);
        put(TRS_ONES, TRS_ONES, hdr, 1, 0);
        put(par(8'h45), par(8'h45), hdr, 1, 0);
        put(par(8'h01), par(8'h01), hdr, 1, 0);
        put(par(dc), par(dc), hdr, 1, 0);
        repeat (dc) put(par(8'($urandom)), par(8'($urandom)), hdr, 1, 0);
        put(par(8'h5a), par(8'h5a), hdr, 1, 0);
        gap(3);
        put(TRS_ONES, TRS_ONES, 0, 1, 0);
        repeat (2) put(TRS_ZERO, TRS_ZERO, 0, 1, 0);
        put(10'h22c, 10'h22c, 0, !sav_sel, care);
        crc_c = '0;
        crc_y = '0;
        gap(8);
    endtask
    // output lags input by seven edges; a pause in driving would skew this
    always begin
        @(posedge clock);
        #1;
        if (q.size() == 8) begin
            e = q.pop_front();
            `CHK(video_out, e.w)
            `CHK(chroma_anc_present, e.ac)
            `CHK(luma_anc_present, e.ay)
            `CHK(fifo_load_n, e.fl)
            if (e.care) begin
                `CHK(chroma_crc_error, e.ec)
                `CHK(luma_crc_error, e.ey)
                `CHK(line_number_fault, e.lf)
            end
        end
    end
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(31));
        repeat (4) @(posedge clock);
        resetn <= 1;
        bus(0, REG_MASK, 0);
        `CHK(rd[5:0], MASK_RESET)
        bus(0, REG_CONTROL, 0);
        `CHK(rd[1:0], CONTROL_RESET)
        bus(1, REG_MASK, 32'h4);
        bus(1, 5'h1c, 32'hffffffff);
        bus(0, 5'h1c, 0);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 11; i++) begin
            if (i == 8) fork
                gap(6);
                bus(1, REG_CONTROL, 32'h3);
            join
            sav_sel = i >= 8;
            fly = i >= 8;
            fld = i == 2;
            bad_c = i == 3;
            bad_y = i == 4;
            send_line(lns[i], i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom_range(20, 1)),
                i != 9, i != 0);
        end
        fork
            gap(40);
            begin
                `CHK(irq, 1'b1)
                bus(0, REG_STATUS, 0);
                `CHK(rd[5:0], 6'h3f)
                #1;
                `CHK(irq, 1'b0)
                bus(0, REG_STATUS, 0);
                `CHK(rd[5:0], 6'h00)
                bus(0, REG_FORMAT, 0);
                `CHK(rd[3:0], FMT_UNKNOWN_I)
                `CHK(detected_format_code, FMT_UNKNOWN_I)
                bus(0, REG_LINE, 0);
                `CHK(rd[10:0], 11'h001)
                bus_off <= 1;
                repeat (2) @(posedge clock);
                `CHK(out_bus, 20'hzzzzz)
                bus_off <= 0;
                @(posedge clock);
                #1;
                `CHK(out_bus, video_out)
            end
        join
        // a frozen enable must stall the write until it returns
        fork
            bus(1, REG_MASK, 32'h2a);
            begin
                clk_en <= 0;
                repeat (3) @(posedge clock);
                `CHK(waitrequest, 1'b1)
                clk_en <= 1;
            end
        join
        bus(0, REG_MASK, 0);
        `CHK(rd[5:0], 6'h2a)
        `CHK(loads, 11)
        `CHK(last_load, {2{10'h22c}})
        summarize();
    end
endmodule // video_deformat_output_status_tb
